// ### logic/vdd_defs.svh
// Constants for the vector driven transfer engine: register map, field
// positions, descriptor layout and reset values.
// Assumes inclusion by the package and the port checker only.
`ifndef VDD_DEFS_SVH
`define VDD_DEFS_SVH

`define VDD_NSRC 8
`define VDD_BUF_BYTES 32
`define VDD_LVL_W 3
`define VDD_LVL_DMA 3'h7

`define VDD_REG_CTRL 12'h000
`define VDD_REG_LEVEL 12'h004
`define VDD_REG_VBASE 12'h008
`define VDD_REG_STAT 12'h00C

`define VDD_CTRL_DMA 0
`define VDD_CTRL_FAST 1
`define VDD_CTRL_THR_LO 4
`define VDD_CTRL_THR_HI 6
`define VDD_RST_DMA 1'b0
`define VDD_RST_FAST 1'b0
`define VDD_RST_THR 3'h0
`define VDD_RST_LEVEL 24'h00_0000
`define VDD_RST_VBASE 24'h00_0000

`define VDD_STAT_BUSY 0
`define VDD_STAT_SRC_LO 4
`define VDD_STAT_SRC_HI 6
`define VDD_STAT_CNT_LO 16
`define VDD_STAT_CNT_HI 31

`define VDD_M_W16 0
`define VDD_M_IMM 1
`define VDD_M_UPDS 2
`define VDD_M_UPDD 3
`define VDD_M_OPER 4
`define VDD_M_BURST_SELECT 5
`define VDD_M_REPEAT_GROUP_SELECT 6
`define VDD_M_CHAIN 7
`define VDD_M_COMPLETION_INTERRUPT_ENABLE 8
`define VDD_M_CNT_LO 9
`define VDD_M_CNT_HI 11

`define VDD_OFF_MODE_HI 5'h01
`define VDD_OFF_CNT 5'h02
`define VDD_OFF_CNT_HI 5'h03
`define VDD_OFF_SRC 6'h04
`define VDD_OFF_OPR 6'h06
`define VDD_OFF_DST_PLAIN 6'h06
`define VDD_OFF_DST_CALC 6'h08
`define VDD_LEN_HDR 6'h04
`define VDD_LEN_PLAIN 6'h08
`define VDD_LEN_OPR 6'h02
`define VDD_LEN_PTR 6'h04
`define VDD_LEN_HALF 6'h02
`define VDD_VEC_LAST 6'h03

`endif

// ### logic/vdd_pkg.sv
// Types for the vector driven transfer engine.
// Assumes vdd_defs.svh is on the include path.
`include "vdd_defs.svh"

package vdd_pkg;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_VEC = 9'h002,
    S_FETCH = 9'h004,
    S_SRC = 9'h008,
    S_OPR = 9'h010,
    S_DST = 9'h020,
    S_WBK = 9'h040,
    S_CHN = 9'h080,
    S_FIN = 9'h100
  } vdd_state_e;

  typedef logic [`VDD_BUF_BYTES-1:0][7:0] vdd_buf_t;

  typedef struct packed {
    vdd_state_e st;
    logic dma_sel;
    logic fast_sel;
    logic [2:0] thr;
    logic [23:0] lvl;
    logic [23:0] vbase;
    logic [31:0] prdata;
    logic [2:0] src;
    logic [23:0] base;
    vdd_buf_t dbuf;
    logic [5:0] k;
    logic [2:0] grp;
    logic [15:0] sval;
    logic [15:0] oval;
    logic mreq;
    logic mwe;
    logic [23:0] maddr;
    logic [7:0] mwdata;
    logic [`VDD_NSRC-1:0] ack;
    logic done;
    logic [31:0] handler;
  } vdd_state_s;

endpackage

// ### logic/vdd_top.sv
// Vector driven transfer engine: takes level-7 peripheral requests,
// fetches a descriptor through the request's vector, moves data.
// Assumes an APB master on pclk and a byte-wide memory port whose
// ack comes from logic on the same clock; requests are held until acked.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns

// Functional notes
// RQ1: Level-7 request starts transfer when selected.
// RQ2: Software never sets both select bits.
// RQ3: Software picks a select before level 7.
// RQ4: DMA select reset value; software clears it.
// RQ5: Wake only above wake level threshold.
// RQ6: Fast interrupt allows one level-7 source.
// RQ7: Descriptor holds fields in fixed order.
// RQ8: Short fields two bytes, pointers four bytes.
// RQ9: Descriptor length follows selected options.
// RQ10: Start ignores processor flag and priority.
// RQ11: Claimed requests never reach normal interrupts.
// RQ12: Descriptor address comes from request vector.
// RQ13: Units 8 or 16 bits, 64K space.
// RQ14: 16-bit access at top uses next byte.
// RQ15: Increment by unit size, independently selectable.
// RQ16: Incrementing address wraps to zero.
// RQ17: Immediate uses source entry, low byte for 8-bit.
// RQ18: Calculation adds operand, operand follows source.
// RQ19: Burst and group bits; zero count idles.
// RQ20: Single mode moves one unit per request.
// RQ21: Burst runs to zero, interrupts held off.
// RQ22: Software keeps descriptors in RAM.
// RQ23: Chain rewrites vector before completion interrupt.
// RQ24: Group count sets pairs per request.
// RQ25: Counter and addresses written back each request.
module vdd_top
  import vdd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`VDD_NSRC-1:0] irq_req,
  output logic [`VDD_NSRC-1:0] irq_ack,
  output logic [`VDD_NSRC-1:0] irq_pass,
  output logic wake,
  output logic busy,
  output logic irq_hold,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic done_pulse,
  output logic [31:0] done_handler
);

  vdd_state_s r;
  vdd_state_s n;

  logic dma_on;
  logic [`VDD_NSRC-1:0] claim;
  logic [`VDD_NSRC-1:0] wk;
  logic [15:0] mode;
  logic [15:0] cnt;
  logic [2:0] gcnt;
  logic [5:0] nb;
  logic [15:0] inc;
  logic [5:0] offs;
  logic [5:0] offd;
  logic [5:0] offc;
  logic [5:0] offi;
  logic [5:0] len;
  logic [15:0] sfield;
  logic [15:0] ofield;
  logic [15:0] dfield;
  logic [15:0] sum;
  logic [23:0] vaddr;
  logic lastg;
  logic step;
  logic hit;

  function automatic logic [15:0] rd16(input vdd_buf_t b, input logic [5:0] o);
    rd16 = {b[o[4:0] + 5'h01], b[o[4:0]]};
  endfunction

  // Level 7 belongs to the engine only while fast interrupt is off
  assign dma_on = r.dma_sel & ~r.fast_sel; // RQ1

  generate
    for (genvar i = 0; i < `VDD_NSRC; i++) begin : g_src
      logic [2:0] lv;
      assign lv = r.lvl[i*`VDD_LVL_W +: `VDD_LVL_W];
      // No gating by processor flag or priority
      assign claim[i] = irq_req[i] & dma_on & (lv == `VDD_LVL_DMA); // RQ1 RQ10
      assign irq_pass[i] = irq_req[i] & ~claim[i]; // RQ11
      assign wk[i] = irq_req[i] & (lv > r.thr); // RQ5
    end
  endgenerate

  assign wake = |wk; // RQ5

  assign mode = {r.dbuf[`VDD_OFF_MODE_HI], r.dbuf[0]};
  assign cnt = {r.dbuf[`VDD_OFF_CNT_HI], r.dbuf[`VDD_OFF_CNT]};
  assign gcnt = mode[`VDD_M_CNT_HI:`VDD_M_CNT_LO]; // RQ24
  assign nb = mode[`VDD_M_W16] ? 6'h02 : 6'h01; // RQ13
  assign inc = mode[`VDD_M_W16] ? 16'h0002 : 16'h0001; // RQ15

  // Field offsets follow the option bits in the fixed descriptor order
  assign offs = mode[`VDD_M_REPEAT_GROUP_SELECT] ? `VDD_LEN_HDR + {1'b0, r.grp, 2'b00} : `VDD_OFF_SRC; // RQ7
  assign offd = mode[`VDD_M_REPEAT_GROUP_SELECT] ? offs + `VDD_LEN_HALF :
                mode[`VDD_M_OPER] ? `VDD_OFF_DST_CALC : `VDD_OFF_DST_PLAIN; // RQ7
  assign offc = offd + `VDD_LEN_HALF;
  assign offi = offc + (mode[`VDD_M_CHAIN] ? `VDD_LEN_PTR : 6'h00);
  assign len = mode[`VDD_M_REPEAT_GROUP_SELECT] ? `VDD_LEN_HDR + {1'b0, gcnt, 2'b00} :
               `VDD_LEN_PLAIN + (mode[`VDD_M_OPER] ? `VDD_LEN_OPR : 6'h00) +
               (mode[`VDD_M_CHAIN] ? `VDD_LEN_PTR : 6'h00) +
               (mode[`VDD_M_COMPLETION_INTERRUPT_ENABLE] ? `VDD_LEN_PTR : 6'h00); // RQ9

  assign sfield = rd16(r.dbuf, offs);
  assign ofield = rd16(r.dbuf, `VDD_OFF_OPR);
  assign dfield = rd16(r.dbuf, offd);
  assign sum = r.sval + r.oval; // RQ18
  assign vaddr = r.vbase + 24'({r.src, 2'b00}) + 24'(r.k); // RQ12
  assign lastg = ~mode[`VDD_M_REPEAT_GROUP_SELECT] | (r.grp == gcnt - 3'h1); // RQ24
  assign step = r.mreq & mem_ack;

  assign hit = (paddr == `VDD_REG_CTRL) | (paddr == `VDD_REG_LEVEL) |
               (paddr == `VDD_REG_VBASE) | (paddr == `VDD_REG_STAT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = r.prdata;

  assign busy = (r.st != S_IDLE);
  // No interrupt is taken while a burst or group is in flight
  // Mode bits belong to the previous descriptor until the first two fetched bytes are in,
  // so the hold only starts once the whole descriptor fetch is done
  assign irq_hold = busy & (r.st != S_VEC) & (r.st != S_FETCH) &
                    (mode[`VDD_M_BURST_SELECT] | mode[`VDD_M_REPEAT_GROUP_SELECT]); // RQ21
  assign irq_ack = r.ack;
  assign mem_req = r.mreq;
  assign mem_we = r.mwe;
  assign mem_addr = r.maddr;
  assign mem_wdata = r.mwdata;
  assign done_pulse = r.done;
  assign done_handler = r.handler;

  always_comb begin
    logic go;
    logic we;
    logic [23:0] a;
    logic [7:0] wd;
    logic [15:0] nc;
    n = r;
    go = 1'b0;
    we = 1'b0;
    a = 24'h00_0000;
    wd = 8'h00;
    nc = cnt - 16'h0001;
    n.ack = '0;
    n.done = 1'b0;

    if (psel & ~penable) begin
      case (paddr)
        `VDD_REG_CTRL: begin
          n.prdata = 32'h0000_0000;
          n.prdata[`VDD_CTRL_DMA] = r.dma_sel;
          n.prdata[`VDD_CTRL_FAST] = r.fast_sel;
          n.prdata[`VDD_CTRL_THR_HI:`VDD_CTRL_THR_LO] = r.thr;
        end
        `VDD_REG_LEVEL: n.prdata = {8'h00, r.lvl};
        `VDD_REG_VBASE: n.prdata = {8'h00, r.vbase};
        `VDD_REG_STAT: begin
          n.prdata = 32'h0000_0000;
          n.prdata[`VDD_STAT_BUSY] = busy;
          n.prdata[`VDD_STAT_SRC_HI:`VDD_STAT_SRC_LO] = r.src;
          n.prdata[`VDD_STAT_CNT_HI:`VDD_STAT_CNT_LO] = cnt;
        end
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    if (psel & penable & pwrite) begin
      case (paddr)
        `VDD_REG_CTRL: begin
          n.dma_sel = pwdata[`VDD_CTRL_DMA]; // RQ4
          n.fast_sel = pwdata[`VDD_CTRL_FAST];
          n.thr = pwdata[`VDD_CTRL_THR_HI:`VDD_CTRL_THR_LO];
        end
        `VDD_REG_LEVEL: n.lvl = pwdata[23:0];
        `VDD_REG_VBASE: n.vbase = pwdata[23:0];
        default: ;
      endcase
    end

    case (r.st)
      S_IDLE: begin
        for (int i = `VDD_NSRC - 1; i >= 0; i--) begin
          if (claim[i]) begin
            n.src = 3'(i);
          end
        end
        if (|claim) begin
          n.ack[n.src] = 1'b1;
          n.k = 6'h00;
          n.st = S_VEC;
        end
      end
      S_VEC: begin
        go = 1'b1;
        a = vaddr; // RQ12
        if (step) begin
          if (r.k < `VDD_VEC_LAST) begin
            n.base[r.k[1:0]*8 +: 8] = mem_rdata;
          end
          n.k = r.k + 6'h01;
          if (r.k == `VDD_VEC_LAST) begin
            n.k = 6'h00;
            n.st = S_FETCH;
          end
        end
      end
      S_FETCH: begin
        go = 1'b1;
        a = r.base + 24'(r.k); // RQ8
        if (step) begin
          n.dbuf[r.k[4:0]] = mem_rdata;
          n.k = r.k + 6'h01;
          if (r.k == 6'(`VDD_OFF_CNT_HI) && {mem_rdata, r.dbuf[`VDD_OFF_CNT]} == 16'h0000) begin
            n.st = S_IDLE; // RQ19
          end else if (r.k > 6'(`VDD_OFF_CNT_HI) && r.k == len - 6'h01) begin
            n.k = 6'h00;
            n.grp = 3'h0;
            n.oval = 16'h0000;
            n.st = S_SRC;
          end
        end
      end
      S_SRC: begin
        if (mode[`VDD_M_IMM]) begin
          n.sval = sfield; // RQ17
          n.st = mode[`VDD_M_OPER] ? S_OPR : S_DST;
        end else begin
          go = 1'b1;
          // 17-bit sum reaches past the top of the 64K space
          a = 24'(sfield) + 24'(r.k); // RQ14
          if (step) begin
            n.sval[r.k[0]*8 +: 8] = mem_rdata;
            n.k = r.k + 6'h01;
            if (r.k == nb - 6'h01) begin
              n.k = 6'h00;
              n.st = mode[`VDD_M_OPER] ? S_OPR : S_DST;
            end
          end
        end
      end
      S_OPR: begin
        go = 1'b1;
        a = 24'(ofield) + 24'(r.k); // RQ14
        if (step) begin
          n.oval[r.k[0]*8 +: 8] = mem_rdata; // RQ18
          n.k = r.k + 6'h01;
          if (r.k == nb - 6'h01) begin
            n.k = 6'h00;
            n.st = S_DST;
          end
        end
      end
      S_DST: begin
        go = 1'b1;
        we = 1'b1;
        a = 24'(dfield) + 24'(r.k); // RQ14
        wd = sum[r.k[0]*8 +: 8]; // RQ17
        if (step) begin
          n.k = r.k + 6'h01;
          if (r.k == nb - 6'h01) begin
            n.k = 6'h00;
            n.oval = 16'h0000;
            // 16-bit adds wrap past the top of the space
            if (mode[`VDD_M_UPDS]) begin
              {n.dbuf[offs[4:0] + 5'h01], n.dbuf[offs[4:0]]} = sfield + inc; // RQ15 RQ16
              if (mode[`VDD_M_OPER]) begin
                {n.dbuf[`VDD_OFF_OPR + 5'h01], n.dbuf[`VDD_OFF_OPR]} = ofield + inc; // RQ18
              end
            end
            if (mode[`VDD_M_UPDD]) begin
              {n.dbuf[offd[4:0] + 5'h01], n.dbuf[offd[4:0]]} = dfield + inc; // RQ15 RQ16
            end
            if (lastg) begin
              {n.dbuf[`VDD_OFF_CNT_HI], n.dbuf[`VDD_OFF_CNT]} = nc; // RQ20
            end
            if (~lastg) begin
              n.grp = r.grp + 3'h1; // RQ24
              n.st = S_SRC;
            end else if (mode[`VDD_M_BURST_SELECT] & ~mode[`VDD_M_REPEAT_GROUP_SELECT] & (nc != 16'h0000)) begin
              n.st = S_SRC; // RQ21
            end else begin
              n.k = 6'(`VDD_OFF_CNT);
              n.st = S_WBK;
            end
          end
        end
      end
      S_WBK: begin
        go = 1'b1;
        we = 1'b1;
        a = r.base + 24'(r.k); // RQ25
        wd = r.dbuf[r.k[4:0]];
        if (step) begin
          n.k = r.k + 6'h01;
          if (r.k == len - 6'h01) begin
            n.k = 6'h00;
            n.st = (cnt == 16'h0000 && mode[`VDD_M_CHAIN] && ~mode[`VDD_M_REPEAT_GROUP_SELECT]) ? S_CHN : S_FIN;
          end
        end
      end
      S_CHN: begin
        go = 1'b1;
        we = 1'b1;
        a = vaddr; // RQ23
        wd = r.dbuf[offc[4:0] + r.k[4:0]];
        if (step) begin
          n.k = r.k + 6'h01;
          if (r.k == `VDD_VEC_LAST) begin
            n.k = 6'h00;
            n.st = S_FIN;
          end
        end
      end
      S_FIN: begin
        // Completion is raised only after any vector rewrite
        if (cnt == 16'h0000 && mode[`VDD_M_COMPLETION_INTERRUPT_ENABLE] && ~mode[`VDD_M_REPEAT_GROUP_SELECT]) begin
          n.done = 1'b1; // RQ20 RQ21 RQ23
          n.handler = {rd16(r.dbuf, offi + `VDD_LEN_HALF), rd16(r.dbuf, offi)}; // RQ8
        end
        n.st = S_IDLE;
      end
      default: n.st = S_IDLE;
    endcase

    // One idle cycle between byte accesses keeps the request registered
    if (go & ~r.mreq) begin
      n.mreq = 1'b1;
      n.maddr = a;
      n.mwe = we;
      n.mwdata = wd;
    end else if (step) begin
      n.mreq = 1'b0;
      n.mwe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= S_IDLE;
      r.dma_sel <= `VDD_RST_DMA; // RQ4
      r.fast_sel <= `VDD_RST_FAST;
      r.thr <= `VDD_RST_THR;
      r.lvl <= `VDD_RST_LEVEL;
      r.vbase <= `VDD_RST_VBASE;
    end else begin
      r <= n;
    end
  end

endmodule

// ### tb/vdd_chk.sv
// Port checker for the vector driven transfer engine.
// Assumes one pclk domain and binding onto vdd_top.
`timescale 1ns/1ns
`include "vdd_defs.svh"
module vdd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`VDD_NSRC-1:0] irq_req,
  input wire logic [`VDD_NSRC-1:0] irq_ack,
  input wire logic [`VDD_NSRC-1:0] irq_pass,
  input wire logic busy,
  input wire logic irq_hold,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic done_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    |irq_ack;
  endsequence
  sequence s_vec;
    mem_req && !mem_we;
  endsequence
  property p_start;
    s_take |-> busy ##1 s_vec;
  endproperty
  property p_onehot;
    $onehot0(irq_ack);
  endproperty
  property p_cause;
    |irq_ack |-> (irq_ack & ~$past(irq_req)) == '0;
  endproperty
  // A claimed request must never leak to the normal interrupt path
  property p_pass;
    ((irq_pass & ~irq_req) | (irq_ack & irq_pass)) == '0;
  endproperty
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_addr, mem_wdata});
  endproperty
  property p_drop;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  property p_busy;
    mem_req |-> busy;
  endproperty
  property p_done;
    done_pulse |=> !done_pulse;
  endproperty
  property p_irq_hold;
    irq_hold |-> busy;
  endproperty
  property p_space;
    mem_req |-> mem_addr <= 24'h01_0000;
  endproperty
  a_start: assert property (p_start) else $error("no vector fetch after ack");
  a_onehot: assert property (p_onehot) else $error("several acks at once");
  a_cause: assert property (p_cause) else $error("ack without request");
  a_pass: assert property (p_pass) else $error("claimed request passed on");
  a_hold: assert property (p_hold) else $error("memory request changed before ack");
  a_drop: assert property (p_drop) else $error("memory request held after ack");
  a_busy: assert property (p_busy) else $error("memory access while idle");
  a_done: assert property (p_done) else $error("completion pulse too long");
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt hold while idle");
  a_space: assert property (p_space) else $error("address out of space");
endmodule

bind vdd_top vdd_chk i_chk (.pclk, .presetn, .irq_req, .irq_ack, .irq_pass, .busy, .irq_hold,
  .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .done_pulse);

// ### tb/vdd_mem.sv
// Byte-wide RAM on the engine's memory port, holding vectors and descriptors.
// Assumes requests are held until ack; latency is set by the bench.
`timescale 1ns/1ns
module vdd_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:131071];
  logic [1:0] cnt;
  // Outside an ack the data lines change every cycle a request waits, so stale data is never read
  assign mem_rdata = mem_ack ? mem[mem_addr[16:0]] : ~mem_addr[7:0] ^ {6'h0, cnt};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
    end else if (mem_req && mem_ack) begin
      if (mem_we) mem[mem_addr[16:0]] <= mem_wdata;
      mem_ack <= 1'b0;
      cnt <= 2'h0;
    end else if (mem_req) begin
      mem_ack <= cnt >= lat;
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// ### tb/test_interrupt_driven_dma_transfer.sv
// Self-checking bench: drives APB and requests, compares against a reference model.
// Assumes vdd_pkg, vdd_mem and vdd_chk are compiled first.
`timescale 1ns/1ns
module test_interrupt_driven_dma_transfer;
  import vdd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake, busy, irq_hold, perr;
  logic mem_req, mem_we, mem_ack, done_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, done_handler, rdv, hand;
  logic [7:0] irq_req, irq_ack, irq_pass, mem_wdata, mem_rdata;
  logic [23:0] mem_addr;
  logic [1:0] lat;
  logic [15:0] seed;
  logic [7:0] rm [0:131071];
  int miscompares, n_tests, n_done;

  vdd_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq_req, .irq_ack, .irq_pass, .wake, .busy, .irq_hold, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .done_pulse, .done_handler);
  vdd_mem i_mem (.pclk, .presetn, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (done_pulse === 1'b1) begin
      n_done++;
      hand = done_handler;
    end
  end

  function automatic int rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return int'(seed);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1);
    rdv = prdata;
    perr = pslverr;
    chk("apb_wait", 1, t);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic put(input int a, input int v, input int n);
    for (int i = 0; i < n; i++) begin
      rm[a + i] = 8'(v >> (8 * i));
      i_mem.mem[a + i] = 8'(v >> (8 * i));
    end
  endtask

  task automatic hw(input int a, input int m, input int c, input int p, input int q);
    put(a, m, 2);
    put(a + 2, c, 2);
    put(a + 4, p, 2);
    put(a + 6, q, 2);
  endtask

  function automatic int rd(input int a, input int n);
    rd = 0;
    for (int i = 0; i < n; i++) rd |= int'(rm[a + i]) << (8 * i);
  endfunction

  task automatic wr(input int a, input int v, input int n);
    for (int i = 0; i < n; i++) rm[a + i] = 8'(v >> (8 * i));
  endtask

  task automatic model(input int s, output int ed, output int eh);
    int v, d, md, c, sa, oa, da, w, x, len;
    v = 16'h0100 + 4 * s;
    d = rd(v, 3);
    md = rd(d, 2);
    c = rd(d + 2, 2);
    w = md[0] + 1;
    ed = 0;
    if (c == 0) return;
    if (md[6]) begin
      for (int k = 0; k < md[11:9]; k++) wr(rd(d + 6 + 4 * k, 2), rd(rd(d + 4 + 4 * k, 2), w), w);
      wr(d + 2, c - 1, 2);
      return;
    end
    sa = rd(d + 4, 2);
    oa = rd(d + 6, 2);
    len = md[4] ? 10 : 8;
    da = rd(d + len - 2, 2);
    repeat (md[5] ? c : 1) begin
      x = md[1] ? sa : rd(sa, w);
      if (md[4]) x += rd(oa, w);
      wr(da, x, w);
      if (md[2]) sa = (sa + w) & 16'hFFFF;
      if (md[2]) oa = (oa + w) & 16'hFFFF;
      if (md[3]) da = (da + w) & 16'hFFFF;
      c--;
    end
    wr(d + 2, c, 2);
    wr(d + 4, sa, 2);
    if (md[4]) wr(d + 6, oa, 2);
    wr(d + len - 2, da, 2);
    if (c == 0 && md[7]) wr(v, rd(d + len, 4), 4);
    ed = c == 0 && md[8];
    eh = rd(d + len + (md[7] ? 4 : 0), 4);
  endtask

  task automatic req(input int s, input logic ex);
    int t, nd, ed, eh, md;
    logic hd;
    nd = n_done;
    lat <= 2'(rnd());
    irq_req[s] <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (irq_ack[s] !== 1'b1 && t < 8);
    chk("irq_ack", ex, irq_ack[s]);
    chk("irq_pass", !ex, irq_pass[s]);
    chk("busy", ex, busy);
    irq_req[s] <= 1'b0;
    t = 0;
    hd = 1'b0;
    do begin
      @(posedge pclk);
      t++;
      hd = hd | (irq_hold === 1'b1);
    end while (busy !== 1'b0 && t < 3000);
    chk("idle", 1'b0, busy);
    repeat (3) @(posedge pclk);
    md = ex ? rd(rd(16'h0100 + 4 * s, 3), 4) : 0;
    chk("irq_hold", (md[5] | md[6]) && md[31:16] != 0, hd);
    ed = 0;
    if (ex) model(s, ed, eh);
    for (int a = 0; a < 32'h0001_0010; a++) begin
      if (a < 16'h0500 || a >= 16'hFFF0) chk($sformatf("mem_%0h", a), rm[a], i_mem.mem[a]);
    end
    chk("done", ed, n_done - nd);
    if (ed) chk("handler", eh, hand);
  endtask

  initial begin
    int x, thr;
    logic [23:0] lv;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    irq_req = 8'h00;
    lat = 2'h0;
    seed = 16'h004F;
    miscompares = 0;
    n_tests = 0;
    n_done = 0;
    for (int a = 0; a < 131072; a++) begin
      x = rnd();
      rm[a] = 8'(x);
      i_mem.mem[a] = 8'(x);
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      chk("reset_value", 32'h0000_0000, rdv);
    end
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk("unmapped_err", 1'b1, perr);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped_data", 32'h0000_0000, rdv);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("stat_ro", 32'h0000_0000, rdv);
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < 8; i++) lv[3 * i +: 3] = 3'(rnd() % 7);
      thr = rnd() % 7;
      apb(1'b1, 12'h004, {8'h00, lv});
      apb(1'b1, 12'h000, 32'(thr << 4));
      irq_req <= 8'(rnd());
      repeat (2) @(posedge pclk);
      x = 0;
      for (int i = 0; i < 8; i++) x |= irq_req[i] && lv[3 * i +: 3] > thr;
      chk("wake", x, wake);
      chk("irq_pass_all", irq_req, irq_pass);
    end
    irq_req <= 8'h00;
    hw(16'h0200, 16'h010D, 2, 16'h0400, 16'hFFFF);
    put(16'h0208, 32'h0001_2340, 4);
    hw(16'h0220, 16'h01AA, 3, 16'hA5C3, 16'h0420);
    put(16'h0228, 32'h0000_0280, 4);
    put(16'h022C, 32'h0003_4560, 4);
    hw(16'h0280, 16'h0015, 1, 16'h0440, 16'h0450);
    put(16'h0288, 16'h0460, 2);
    hw(16'h0240, 16'h010D, 0, 16'h0400, 16'h0410);
    hw(16'h0260, 16'h0640, 5, 16'h0470, 16'h0480);
    hw(16'h0268, 16'h0471, 16'h0490, 16'h0472, 16'h04A0);
    for (int s = 0; s < 4; s++) put(16'h0100 + 4 * s, 16'h0200 + 16'h0020 * s, 4);
    apb(1'b1, 12'h008, 32'h0000_0100);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("vbase", 32'h0000_0100, rdv);
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0FFF);
    req(0, 1'b1);
    req(0, 1'b1);
    req(1, 1'b1);
    req(1, 1'b1);
    req(2, 1'b1);
    req(3, 1'b1);
    req(5, 1'b0);
    apb(1'b1, 12'h004, 32'h0000_7000);
    apb(1'b1, 12'h000, 32'h0000_0002);
    req(4, 1'b0);
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    finish_test();
  end
endmodule
